// ---- logic/fmd_regs.vh ----
// Behaviour
// - combine select bit six chooses freefall/motion
// - all axis enables zero disables detector
// - latch and combine bits give four modes
// - event active sets after debounce completes
// - only enabled axes take part
// - unlatched decrement mode clears after delay
// - unlatched freefall clear mode drops at once, resets delay
// - unlatched motion clear mode drops flag immediately
// - unlatched freefall: read does not clear
// - unlatched motion: read clears nothing
// - axis flags track raw compare while idle
// - latched freefall holds flag until read
// - latched read clears flag and counter
// - latched mode freezes axis flags from event until read
// - 7-bit threshold, above is motion
// - AND for freefall, OR for motion
// - polarity zero positive, one negative
// - disabled axis reads zero flags
`ifndef FMD_REGS_VH
`define FMD_REGS_VH
`define FMD_CFG_ADDR 8'h15
`define FMD_SRC_ADDR 8'h16
`define FMD_CFG_RESET 8'h00
`define FMD_SRC_RESET 8'h00
`define FMD_CFG_LATCH_BIT 7
`define FMD_CFG_COMBINE_BIT 6
`define FMD_CFG_XEN_BIT 3
`define FMD_SRC_EA_BIT 7
`define FMD_CNT_RESET 8'h00
`endif

// ---- logic/fmd_axis_cmp.v ----
`timescale 1ns/1ps
// per-axis magnitude compare against threshold, registered
module fmd_axis_cmp (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire sample_valid,
  input wire [13:0] sample,
  input wire [6:0] threshold,
  output reg above_q,
  output reg neg_q
);
  wire [13:0] mag;
  // magnitude of signed sample; upper 7 bits compare with threshold
  assign mag = sample[13] ? (~sample + 14'h0001) : sample;
  // registered compare updated per sample
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      above_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (ce && sample_valid) begin
      above_q <= ({1'b0, mag[13:7]} > {1'b0, threshold});
      neg_q <= sample[13];
    end
  end
endmodule // fmd_axis_cmp

// ---- logic/fmd_detect.v ----
`timescale 1ns/1ps
`include "fmd_regs.vh"
// freefall/motion detector with register port
module fmd_detect (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire sample_valid,
  input wire [13:0] accel_x,
  input wire [13:0] accel_y,
  input wire [13:0] accel_z,
  input wire [6:0] event_threshold,
  input wire [7:0] event_debounce_count,
  input wire debounce_clear_mode,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  output reg event_active_q
);
  reg [7:0] cfg_q;
  wire [5:0] axis_flags;
  reg [7:0] rdata_d;
  wire cfg_wr;
  wire [7:0] cfg_wdata;
  wire latched_clear;
  wire flags_hold;
  wire [5:0] en_mask;
  wire [7:0] src_view;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg ea_d;
  reg sv_q1;
  reg sv_q2;
  wire [2:0] above;
  wire [2:0] neg;
  wire [2:0] en;
  wire [41:0] samples;
  wire latch_en;
  wire motion;
  wire any_en;
  wire [2:0] hit;
  wire cond;
  wire src_rd;
  wire done;
  wire [5:0] raw_flags;
  genvar i;

  assign en = cfg_q[`FMD_CFG_XEN_BIT+2:`FMD_CFG_XEN_BIT];
  assign latch_en = cfg_q[`FMD_CFG_LATCH_BIT];
  assign motion = cfg_q[`FMD_CFG_COMBINE_BIT];
  assign samples = {accel_z, accel_y, accel_x};

  // sample strobe treated as same-domain; two stages align with compare
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sv_q1 <= 1'b0;
      sv_q2 <= 1'b0;
    end else if (ce) begin
      sv_q1 <= sample_valid;
      sv_q2 <= sv_q1;
    end
  end

  // one compare per axis; hit means axis meets the selected condition
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_axis
      fmd_axis_cmp u_cmp (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .sample_valid(sample_valid),
        .sample(samples[i*14 +: 14]),
        .threshold(event_threshold),
        .above_q(above[i]),
        .neg_q(neg[i])
      );
      assign hit[i] = motion ? above[i] : ~above[i];
      assign raw_flags[2*i+1] = en[i] & hit[i];
      assign raw_flags[2*i] = en[i] & hit[i] & neg[i];
    end
  endgenerate

  assign any_en = |en;
  // AND of enabled axes for freefall, OR for motion
  assign cond = any_en & (motion ? |(hit & en) : &(hit | ~en));
  assign src_rd = reg_rd && (reg_addr == `FMD_SRC_ADDR);
  assign done = (cnt_q >= event_debounce_count);

  // debounce counter and event flag next state
  always @* begin
    cnt_d = cnt_q;
    ea_d = event_active_q;
    if (!any_en) begin
      cnt_d = `FMD_CNT_RESET;
      ea_d = 1'b0;
    end else if (sv_q2) begin
      if (cond) begin
        // count up to the programmed value, flag on completion
        if (!done) begin
          cnt_d = cnt_q + 8'h01;
        end
        if (done || (cnt_q + 8'h01 >= event_debounce_count)) begin
          ea_d = 1'b1;
        end
      end else if (!latch_en) begin
        // unlatched: clear mode drops at once, decrement mode waits
        if (debounce_clear_mode) begin
          cnt_d = `FMD_CNT_RESET;
          ea_d = 1'b0;
        end else begin
          if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
          end
          if (cnt_q <= 8'h01) begin
            ea_d = 1'b0;
          end
        end
      end else if (!event_active_q) begin
        // latched and idle: the counter still unwinds
        if (debounce_clear_mode) begin
          cnt_d = `FMD_CNT_RESET;
        end else if (cnt_q != 8'h00) begin
          cnt_d = cnt_q - 8'h01;
        end
      end
    end
    // latched read clears; unlatched read changes nothing
    if (latched_clear) begin
      cnt_d = `FMD_CNT_RESET;
      ea_d = 1'b0;
    end
  end

  // decoded register strobes
  assign cfg_wr = reg_wr && (reg_addr == `FMD_CFG_ADDR);
  assign cfg_wdata = {reg_wdata[7:3], 3'b000}; // unimplemented low bits read zero
  // a source read in latched mode restarts the detector
  assign latched_clear = src_rd && latch_en;
  // latched mode holds axis flags while the event stands
  assign flags_hold = latch_en && event_active_q;

  // disabled axes always read zero flags
  assign en_mask = {en[2], en[2], en[1], en[1], en[0], en[0]};
  // source register as software sees it
  assign src_view = {event_active_q, 1'b0, axis_flags & en_mask};

  // config register; only latch, combine and axis enables are stored
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `FMD_CFG_RESET;
    end else if (ce) begin
      if (cfg_wr) begin
        cfg_q <= cfg_wdata;
      end
    end
  end

  // debounce counter register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `FMD_CNT_RESET;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  // event-active flag register; set only by the debounce logic
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_active_q <= 1'b0;
    end else if (ce) begin
      event_active_q <= ea_d;
    end
  end

  // axis flags: two flops per axis, frozen while a latched event stands
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_flag
      reg [1:0] flag_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flag_q <= 2'b00;
        end else if (ce) begin
          if (latched_clear) begin
            flag_q <= 2'b00;
          end else if (!flags_hold) begin
            flag_q <= raw_flags[2*i +: 2];
          end
        end
      end
      assign axis_flags[2*i +: 2] = flag_q;
    end
  endgenerate

  // read data select for the addressed register
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `FMD_CFG_ADDR: begin
        rdata_d = cfg_q;
      end
      `FMD_SRC_ADDR: begin
        rdata_d = src_view;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // read data register, refreshed on every enabled cycle
  // unmapped addresses read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (ce) begin
      reg_rdata_q <= rdata_d;
    end
  end
endmodule // fmd_detect

// ---- tb/fmd_detect_monitor.sv ----
`timescale 1ns/1ps
// port checker with a shadow of the config register
module fmd_detect_monitor (
  input wire clk, rst_n, ce, sample_valid, reg_wr, reg_rd,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata_q,
  input wire event_active_q
);
  reg [7:0] cfg_q;
  wire r15 = ce && reg_rd && reg_addr == 8'h15;
  wire r16 = ce && reg_rd && reg_addr == 8'h16;
  // shadow follows config writes
  always @(posedge clk or negedge rst_n)
    if (!rst_n) cfg_q <= 8'h00;
    else if (ce && reg_wr && reg_addr == 8'h15) cfg_q <= reg_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cfg_low_zero: assert property (r15 |=> reg_rdata_q[2:0] == 3'h0)
    else $error("cfg low");
  a_ea_mirror: assert property (r16 |=> reg_rdata_q[7] == $past(event_active_q))
    else $error("mirror");
  a_latch_read_clear: assert property (r16 && cfg_q[7] |=> !event_active_q)
    else $error("latch");
  a_disabled_idle: assert property (cfg_q[5:3] == 3'h0 |=> !event_active_q)
    else $error("idle");
  a_axis_off_zero: assert property (r16 && !cfg_q[3] |=> reg_rdata_q[1:0] == 2'h0)
    else $error("axis off");
  a_sample_rise: assert property ($rose(event_active_q) |-> $past(sample_valid, 2) ||
    $past(sample_valid, 3) || $past(sample_valid, 4))
    else $error("rise");
  a_ce_freeze: assert property (!ce |=> $stable(event_active_q) && $stable(reg_rdata_q))
    else $error("ce");
  a_reset_clear: assert property ($rose(rst_n) |-> !event_active_q && reg_rdata_q == 8'h00)
    else $error("reset");
  c_latched: cover property (r16 && cfg_q[7] && event_active_q);
  c_motion: cover property ($rose(event_active_q) && cfg_q[6]);
  c_drop: cover property ($fell(event_active_q) && !cfg_q[7]);
endmodule // fmd_detect_monitor
bind fmd_detect fmd_detect_monitor u_mon (.*);

// ---- tb/fmd_detect_tb.sv ----
`timescale 1ns/1ps
module fmd_detect_tb;
  reg clk = 0, rst_n = 0, ce = 1, sv = 0, wr = 0, rd = 0, clr = 1;
  reg [13:0] ax = 0, ay = 0, az = 0;
  reg [7:0] adr = 0, wd = 0, d;
  reg [31:0] rs = 32'h291d508f;
  integer err_count = 0, n_checks = 0, m;
  integer mcnt = 0;
  reg mea = 0;
  reg [7:0] mcfg = 0, me = 0;
  reg [5:0] mflg = 0;
  reg [13:0] lx = 0, ly = 0, lz = 0;
  wire [7:0] rdq;
  wire ea;
  always #20 clk = ~clk;
  fmd_detect u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .sample_valid(sv), .accel_x(ax),
    .accel_y(ay), .accel_z(az), .event_threshold(7'h10), .event_debounce_count(8'h03),
    .debounce_clear_mode(clr), .reg_wr(wr), .reg_rd(rd), .reg_addr(adr), .reg_wdata(wd),
    .reg_rdata_q(rdq), .event_active_q(ea));
  task stop_test;
    begin
      if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] nm, input [7:0] e, input [7:0] s);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("unexpected %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  function [31:0] xs(input [31:0] v);
    begin
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
    end
  endfunction
  // model: per-axis condition from the last taken sample, threshold 16
  function [2:0] mhit(input [7:0] c);
    integer k, mg;
    reg [13:0] v;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        v = (k == 0) ? lx : (k == 1) ? ly : lz;
        mg = v[13] ? 16384 - v : v;
        mhit[k] = c[6] ? (mg / 128 > 16) : (mg / 128 <= 16);
      end
    end
  endfunction
  // model: raw axis event and polarity flags
  function [5:0] mraw(input [7:0] c);
    integer k;
    reg [2:0] h;
    reg [13:0] v;
    begin
      h = mhit(c);
      for (k = 0; k < 3; k = k + 1) begin
        v = (k == 0) ? lx : (k == 1) ? ly : lz;
        mraw[2*k+1] = c[3+k] & h[k];
        mraw[2*k] = c[3+k] & h[k] & v[13];
      end
    end
  endfunction
  // model: one taken sample, debounce count 3
  task mstep;
    reg [2:0] h, e;
    reg hold;
    begin
      lx = ax;
      ly = ay;
      lz = az;
      e = mcfg[5:3];
      h = mhit(mcfg);
      hold = mcfg[6] ? |(h & e) : &(h | ~e);
      if (e == 0) begin
        mcnt = 0;
        mea = 0;
      end else if (hold) begin
        if (mcnt < 3) mcnt = mcnt + 1;
        if (mcnt >= 3 && !mea) mflg = mraw(mcfg);
        if (mcnt >= 3) mea = 1;
      end else if (!mcfg[7] && clr) begin
        mcnt = 0;
        mea = 0;
      end else if (!mcfg[7]) begin
        if (mcnt > 0) mcnt = mcnt - 1;
        if (mcnt == 0) mea = 0;
      end else if (!mea) begin
        if (clr) mcnt = 0;
        else if (mcnt > 0) mcnt = mcnt - 1;
      end
    end
  endtask
  // one register access, read data lands one cycle on
  task acc(input w, input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= v;
      @(posedge clk);
      wr <= 0;
      rd <= 0;
      #1 d = rdq;
      if (w && a == 8'h15) mcfg = {v[7:3], 3'b000};
      if (!w && a == 8'h16) begin
        me = {mea, 1'b0, (mcfg[7] && mea) ? mflg : mraw(mcfg)};
        if (mcfg[7]) begin
          mea = 0;
          mcnt = 0;
        end
      end
    end
  endtask
  // n samples, high g (x negative) or random low g
  task smp(input integer n, input big);
    repeat (n) begin
      rs = xs(rs);
      @(posedge clk);
      sv <= 1;
      ax <= big ? 14'h3000 : {8'h00, rs[5:0]};
      ay <= big ? 14'h1000 : {8'h00, rs[11:6]};
      az <= big ? 14'h1000 : {8'h00, rs[17:12]};
      @(posedge clk);
      sv <= 0;
      repeat (4) @(posedge clk);
      if (ce) mstep;
      chk("ea", {7'h0, mea}, {7'h0, ea});
    end
  endtask
  initial begin
    #3000000;
    err_count = err_count + 1;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    acc(0, 8'h15, 0);
    chk("cfg", 8'h00, d);
    smp(2, 0);
    acc(0, 8'h16, 0);
    chk("src", 8'h00, d);
    chk("src", me, d);
    acc(1, 8'h16, 8'hff);
    acc(0, 8'h17, 0);
    chk("bad", 8'h00, d);
    acc(1, 8'h15, 8'hff);
    acc(0, 8'h15, 0);
    chk("cfg", 8'hf8, d);
    // every latch and combine mode in turn
    for (m = 0; m < 4; m = m + 1) begin
      acc(1, 8'h15, {m[1:0], 6'h38});
      smp(1, m[0]);
      chk("ea", 8'h00, {7'h0, ea});
      smp(5, m[0]);
      chk("ea", 8'h01, {7'h0, ea});
      acc(0, 8'h16, 0);
      chk("src", m[0] ? 8'hab : 8'h80, m[0] ? d : d & 8'h80);
      chk("src", me, d);
      chk("ea", {7'h0, !m[1]}, {7'h0, ea});
      smp(1, !m[0]);
      chk("ea", 8'h00, {7'h0, ea});
      smp(1, m[0]);
      chk("ea", 8'h00, {7'h0, ea});
    end
    // decrement mode holds the flag, ce low freezes it
    clr <= 0;
    acc(1, 8'h15, 8'h78);
    smp(6, 1);
    ce <= 0;
    smp(4, 0);
    ce <= 1;
    smp(1, 0);
    chk("ea", 8'h01, {7'h0, ea});
    smp(6, 0);
    chk("ea", 8'h00, {7'h0, ea});
    stop_test;
  end
endmodule // fmd_detect_tb
